// [adc_serial_port_clocking_tb.sv]
// self-checking bench of the converter serial port
module adc_serial_port_clocking_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, reset_n, mode_strap, lsb_first, two_wire;
   logic junk = 1'b0;
   logic [23:0] conversion_value;
   adcsp_pkg::adcsp_regs_s trim_regs;
   logic select_n, host_clk, host_d, host_oe, paused, sdio_wire, read_line;
   logic shift_clock_out, shift_clock_oe, sdio_out, sdio_oe;
   logic serial_out_line, serial_out_line_oe;
   logic [2:0] codes [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
   int bad_count = 0;
   int samples_checked = 0;
   // undriven lines flip every cycle so a stale value cannot pass
   assign sdio_wire = sdio_oe ? sdio_out : host_oe ? host_d : junk;
   assign read_line = two_wire ? sdio_wire
      : serial_out_line_oe ? serial_out_line : junk;
   always @(posedge clock) junk <= ~junk;
   adcsp_port adcsp_port_inst (.clock(clock), .reset_n(reset_n),
      .mode_strap(mode_strap), .conversion_value(conversion_value),
      .trim_regs(trim_regs), .select_n(select_n), .shift_clock_in(host_clk),
      .shift_clock_out(shift_clock_out), .shift_clock_oe(shift_clock_oe),
      .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .serial_out_line(serial_out_line),
      .serial_out_line_oe(serial_out_line_oe));
   adcsp_host adcsp_host_inst (.clock(clock), .select_n(select_n),
      .shift_clock(host_clk), .data_drive(host_d), .data_oe(host_oe),
      .paused(paused), .read_line(read_line));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] seen, input logic [23:0] exp,
         input string what);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checked %0d, wrong %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict
   always @(posedge clock) begin
      if (paused) begin
         check({22'h0, sdio_oe, serial_out_line_oe}, 24'h0, "oe");
      end
   end
   function automatic int pos(input int s, input logic asc, input int i);
      int p;
      p = (s == 3) ? 2 : s;
      for (int j = 0; j < i; j++) p = asc ? (p + 1) % 3 : (p + 2) % 3;
      return p;
   endfunction : pos
   function automatic logic [23:0] field(input int r);
      case (r)
         1: return trim_regs.zero;
         2: return trim_regs.pos_span;
         3: return trim_regs.neg_span;
         default: return conversion_value;
      endcase
   endfunction : field
   task automatic do_reset(input logic strap);
      @(posedge clock);
      reset_n <= 1'b0;
      mode_strap <= strap;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////
   // instruction then n data bytes; pz 9 deselects once, between the first two data bytes
   task automatic txn(input logic [7:0] ins, input int n, input int pz,
         inout logic [31:0] b);
      logic [7:0] rb;
      adcsp_host_inst.xfer(ins, lsb_first, 1'b1, 8, rb);
      for (int i = 0; i < n; i++) begin
         if (i == 1 && pz == 9) begin
            adcsp_host_inst.set_select(1'b1);
            adcsp_host_inst.set_select(1'b0);
         end
         adcsp_host_inst.xfer(b[8*i+:8], lsb_first, ins[7], i ? 8 : pz, rb);
         b[8*i+:8] = ins[7] ? b[8*i+:8] : rb;
      end
      repeat (3) @(posedge clock);
   endtask : txn
   task automatic reg_test(input logic [2:0] cfg);
      logic [31:0] b;
      logic [23:0] w, v;
      int s, n;
      b = {28'h0, cfg, 1'b0};
      txn(8'h84, 1, 8, b);
      {two_wire, lsb_first} = {cfg[2], cfg[0]};
      check(trim_regs.setup, {20'h0, cfg, 1'b0}, "setup");
      for (int r = 0; r < 4; r++) begin
         w = 24'($urandom);
         s = $urandom % 4;
         conversion_value <= 24'($urandom);
         for (int i = 0; i < 3; i++) b[8*i+:8] = w[8*pos(s, cfg[1], i)+:8];
         txn({3'h6, codes[r], 2'(s)}, 3, 9, b);
         v = (r == 0) ? conversion_value : w;
         // a result write is dropped and must leave setup alone
         check(r ? field(r) : trim_regs.setup,
            r ? w : {20'h0, cfg, 1'b0}, "written");
         n = 1 + $urandom % 4;
         s = $urandom % 4;
         txn({1'b0, 2'(n - 1), codes[r], 2'(s)}, n, $urandom % 8, b);
         for (int i = 0; i < n; i++) begin
            check(24'(b[8*i+:8]), 24'(v[8*pos(s, cfg[1], i)+:8]), "rd");
         end
      end
   endtask : reg_test
   task automatic self_test();
      int falls, last;
      logic prev;
      logic [23:0] e;
      adcsp_host_inst.set_select(1'b1);
      do_reset(1'b1);
      {falls, last, prev} = {32'h0, 32'h0, 1'b1};
      @(posedge clock);
      adcsp_host_inst.select_n <= 1'b0;
      for (int t = 1; t <= 460; t++) begin
         @(posedge clock);
         // short and long mid-byte deselects, then one in the stall
         if (falls == 10 || falls == 18 || t == 400) begin
            adcsp_host_inst.select_n <= 1'b1;
         end
         if (falls == 12 || t == 300) begin
            adcsp_host_inst.select_n <= 1'b0;
         end
         if (t == 300) last = t;
         #1;
         if (prev && !shift_clock_out) begin
            falls++;
            // start: 29 plus the edge that samples select
            e = falls % 24 == 1 ? 24'h1E :
               (falls % 8 == 1 ? 24'h20 : 24'h08);
            check(24'(t - last), e, "fall spacing");
            last = t;
         end
         prev = shift_clock_out;
      end
      check(24'(falls), 24'h20, "falls");
      check({23'h0, shift_clock_out}, 24'h1, "park");
      check({23'h0, shift_clock_oe}, 24'h1, "clock drive");
   endtask : self_test
   initial begin
      {reset_n, mode_strap, lsb_first, two_wire} = 4'h0;
      conversion_value = 24'h0;
      void'($urandom(23857));
      do_reset(1'b0);
      check(trim_regs.setup, 24'h0, "setup reset");
      for (int r = 1; r < 4; r++) begin
         check(field(r), r == 1 ? 24'h0 : 24'h800000, "trim reset");
      end
      $display("test reset values done");
      adcsp_host_inst.set_select(1'b0);
      for (int c = 0; c < 8; c++) begin
         reg_test(3'(c));
         $display("test config %0d done", c);
      end
      self_test();
      $display("test self clocking done");
      give_verdict();
   end
   initial begin
      // the tests need about 430 us at the legal host clock rate
      #480us;
      bad_count++;
      $display("wrong value at %0t: run did not finish", $time);
      give_verdict();
   end
endmodule : adc_serial_port_clocking_tb

// [adcsp_defs.svh]
// constants of the converter serial port
`ifndef ADCSP_DEFS_SVH
`define ADCSP_DEFS_SVH
// self clocking timing, in master oscillator cycles
`define ADCSP_START_CYC 29
`define ADCSP_STALL_CYC 28
`define ADCSP_HALF_CYC 4
// generator counter end points, start and stall derived from the figures above
`define ADCSP_START_LAST 6'(`ADCSP_START_CYC - 2)
`define ADCSP_STALL_LAST 6'(`ADCSP_STALL_CYC - `ADCSP_HALF_CYC - 1)
`define ADCSP_BYTE_LAST 6'h3F
`define ADCSP_FALL_PHASE 3'h0
`define ADCSP_RISE_PHASE 3'h4
// setup_control field positions
`define ADCSP_TWO_WIRE_BIT 3
`define ADCSP_ASCEND_BIT 2
`define ADCSP_LSB_FIRST_BIT 1
// instruction byte fields
`define ADCSP_INS_WRITE 7
`define ADCSP_INS_NEG 4
`define ADCSP_INS_COUNT 6:5
`define ADCSP_INS_SEL 3:2
`define ADCSP_INS_START 1:0
// start code past the top byte, taken as the top byte
`define ADCSP_START_HIGH 2'h3
// register select codes of instruction bits 3:2
`define ADCSP_SEL_RESULT 2'h0
`define ADCSP_SEL_SETUP 2'h1
`define ADCSP_SEL_ZERO 2'h2
`define ADCSP_SEL_SPAN 2'h3
// byte positions
`define ADCSP_BYTE_TOP 2'h2
`define ADCSP_BYTE_BOT 2'h0
`define ADCSP_BIT_LAST 3'h7
// reset values
`define ADCSP_SETUP_RST 24'h000000
`define ADCSP_ZERO_RST 24'h000000
`define ADCSP_SPAN_RST 24'h800000
`endif

// [adcsp_host.sv]
// host microcontroller model that runs the external shift clock
module adcsp_host (
   // clock
   input wire logic clock,
   // serial pins toward the port
   output logic select_n,
   output logic shift_clock,
   output logic data_drive,
   output logic data_oe,
   output logic paused,
   input wire logic read_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // 200 MHz clock over a 5 MHz shift clock, two levels per period
   localparam int HALF_CYC = 20;
   initial begin
      select_n = 1'b1;
      shift_clock = 1'b1;
      data_drive = 1'b0;
      data_oe = 1'b0;
      paused = 1'b0;
   end
   task automatic set_select(input logic v);
      @(posedge clock);
      select_n <= v;
      repeat (3) @(posedge clock);
   endtask : set_select
   ////////////////////////////////////////////////////////////////////////
   // one byte; clock parked high between bytes, optional mid-byte pause
   task automatic xfer(input logic [7:0] wb, input logic lsb,
         input logic drive, input int pause_at, output logic [7:0] rb);
      int k;
      for (int i = 0; i < 8; i++) begin
         k = lsb ? i : 7 - i;
         @(posedge clock);
         shift_clock <= 1'b0;
         data_drive <= wb[k];
         data_oe <= drive;
         repeat (HALF_CYC - 1) @(posedge clock);
         if (i == pause_at) begin
            select_n <= 1'b1;
            paused <= 1'b1;
            // even toggle count, so we come back at the level we left
            repeat (2) begin
               repeat (HALF_CYC) @(posedge clock);
               shift_clock <= ~shift_clock;
            end
            repeat (2) @(posedge clock);
            select_n <= 1'b0;
            paused <= 1'b0;
            @(posedge clock);
         end
         @(posedge clock);
         rb[k] = read_line;
         shift_clock <= 1'b1;
         repeat (HALF_CYC - 1) @(posedge clock);
      end
   endtask : xfer
endmodule : adcsp_host

// [adcsp_pkg.sv]
// types of the converter serial port
package adcsp_pkg;
   typedef enum logic [0:0] {PH_INSTR, PH_DATA} adcsp_phase_e;
   typedef enum logic [1:0] {GEN_IDLE, GEN_WAIT, GEN_SHIFT, GEN_STALL}
      adcsp_gen_e;
   typedef struct packed {
      logic [23:0] setup;
      logic [23:0] zero;
      logic [23:0] pos_span;
      logic [23:0] neg_span;
   } adcsp_regs_s;
   typedef struct packed {
      adcsp_phase_e phase;
      logic [7:0] instr;
      logic [7:0] wbyte;
      logic [2:0] bit_cnt;
      logic [1:0] byte_ptr;
      logic [1:0] remain;
      logic in_read;
      logic out_bit;
      logic sclk_prev;
      adcsp_gen_e gen;
      logic [5:0] gen_cnt;
      logic sclk_o;
      logic oe_r;
      adcsp_regs_s regs;
   } adcsp_state_s;
endpackage : adcsp_pkg

// [adcsp_port.sv]
// byte organised serial port with host or self generated shift clock
`include "adcsp_defs.svh"

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - two-wire reads on the shared line, three-wire reads on output line
// - every register byte addressable, single or multi byte per cycle
// - bit order and byte direction selectable, any start byte
// - result read only, setup and three trim registers read/write
// - strap low: shift clock is a host driven input
// - strap high: drive shift clock at oscillator/8, park high only
// - self clocking: first transition 29 cycles after select seen low
// - self clocking: one byte of clock, then 28 cycles high, repeating
// - external clock: deselect freezes the port, resumes where stopped
// - external clock reads: outputs released as soon as deselected
// - self clocking: a started byte always runs its eight cycles
// - self clocking: clock held high while select stays inactive
// - self clocking: reselect within a byte acts as never deselected
// - paused multi byte transfer finishes before a new instruction
// - self clocking reads keep driving until the byte's last bit
// - self clocking: deselect in stall releases outputs in one cycle
// - every cycle opens with an instruction byte, then data phase
// - external clock: data outputs high impedance while select is high
module adcsp_port (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // strap and converter side
   input wire logic mode_strap,
   input wire logic [23:0] conversion_value,
   output adcsp_pkg::adcsp_regs_s trim_regs,
   // serial pins
   input wire logic select_n,
   input wire logic shift_clock_in,
   output logic shift_clock_out,
   output logic shift_clock_oe,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic serial_out_line,
   output logic serial_out_line_oe
);

   adcsp_pkg::adcsp_state_s s;
   adcsp_pkg::adcsp_state_s next_s;
   logic ext_active;
   logic rise;
   logic fall;
   logic gen_rise;
   logic gen_fall;
   logic msb_first;
   logic ascend;
   logic drive;
   logic [2:0] bit_idx;
   logic [4:0] lane;
   logic [23:0] word;
   logic [7:0] cur_byte;
   logic [7:0] full_byte;
   logic [1:0] step_ptr;

   ////////////////////////////////////////////////////////////////////////
   // shift events from the pin or the generator
   // pin edges only count while selected, so toggles while away are lost
   assign ext_active = !mode_strap && !select_n;
   assign gen_fall = mode_strap && s.gen == adcsp_pkg::GEN_SHIFT &&
                     s.gen_cnt[2:0] == `ADCSP_FALL_PHASE;
   assign gen_rise = mode_strap && s.gen == adcsp_pkg::GEN_SHIFT &&
                     s.gen_cnt[2:0] == `ADCSP_RISE_PHASE;
   assign rise = mode_strap ? gen_rise :
                 ext_active && shift_clock_in && !s.sclk_prev;
   assign fall = mode_strap ? gen_fall :
                 ext_active && !shift_clock_in && s.sclk_prev;

   ////////////////////////////////////////////////////////////////////////
   // byte and bit selection
   assign msb_first = !s.regs.setup[`ADCSP_LSB_FIRST_BIT];
   assign ascend = s.regs.setup[`ADCSP_ASCEND_BIT];
   assign bit_idx = msb_first ? `ADCSP_BIT_LAST - s.bit_cnt : s.bit_cnt;
   assign lane = {s.byte_ptr, 3'h0};

   always_comb begin
      case (s.instr[`ADCSP_INS_SEL])
         `ADCSP_SEL_RESULT: word = conversion_value;
         `ADCSP_SEL_SETUP: word = s.regs.setup;
         `ADCSP_SEL_ZERO: word = s.regs.zero;
         default: word = s.instr[`ADCSP_INS_NEG] ? s.regs.neg_span :
                         s.regs.pos_span;
      endcase
   end

   assign cur_byte = word[lane +: 8];

   always_comb begin
      full_byte = s.wbyte;
      full_byte[bit_idx] = sdio_in;
   end

   // three bytes per register, pointer wraps both ways
   always_comb begin
      if (ascend) begin
         step_ptr = (s.byte_ptr == `ADCSP_BYTE_TOP) ? `ADCSP_BYTE_BOT :
                    s.byte_ptr + 2'h1;
      end else begin
         step_ptr = (s.byte_ptr == `ADCSP_BYTE_BOT) ? `ADCSP_BYTE_TOP :
                    s.byte_ptr - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_s = s;
      if (ext_active) begin
         next_s.sclk_prev = shift_clock_in;
      end
      // clock generator, select ignored inside a byte
      case (s.gen)
         adcsp_pkg::GEN_IDLE: begin
            if (!select_n) begin
               next_s.gen = adcsp_pkg::GEN_WAIT;
               next_s.gen_cnt = 6'h00;
            end
         end
         adcsp_pkg::GEN_WAIT: begin
            if (select_n) begin
               next_s.gen = adcsp_pkg::GEN_IDLE;
            end else if (s.gen_cnt == `ADCSP_START_LAST) begin
               next_s.gen = adcsp_pkg::GEN_SHIFT;
               next_s.gen_cnt = 6'h00;
            end else begin
               next_s.gen_cnt = s.gen_cnt + 6'h01;
            end
         end
         adcsp_pkg::GEN_SHIFT: begin
            next_s.gen_cnt = s.gen_cnt + 6'h01;
            if (s.gen_cnt == `ADCSP_BYTE_LAST) begin
               next_s.gen = select_n ? adcsp_pkg::GEN_IDLE :
                            adcsp_pkg::GEN_STALL;
               next_s.gen_cnt = 6'h00;
            end
         end
         adcsp_pkg::GEN_STALL: begin
            if (select_n) begin
               next_s.gen = adcsp_pkg::GEN_IDLE;
            end else if (s.gen_cnt == `ADCSP_STALL_LAST) begin
               next_s.gen = adcsp_pkg::GEN_SHIFT;
               next_s.gen_cnt = 6'h00;
            end else begin
               next_s.gen_cnt = s.gen_cnt + 6'h01;
            end
         end
         default: next_s.gen = adcsp_pkg::GEN_IDLE;
      endcase
      if (!mode_strap) begin
         next_s.gen = adcsp_pkg::GEN_IDLE;
      end
      // generated clock rests high, never low
      if (gen_fall) begin
         next_s.sclk_o = 1'b0;
      end else if (gen_rise || next_s.gen != adcsp_pkg::GEN_SHIFT) begin
         next_s.sclk_o = 1'b1;
      end
      // launch read data on falling edges
      if (fall && s.in_read) begin
         next_s.out_bit = cur_byte[bit_idx];
      end
      // capture on rising edges
      if (rise) begin
         next_s.wbyte = full_byte;
         next_s.bit_cnt = s.bit_cnt + 3'h1;
         if (s.bit_cnt == `ADCSP_BIT_LAST) begin
            next_s.wbyte = 8'h00;
            if (s.phase == adcsp_pkg::PH_INSTR) begin
               next_s.instr = full_byte;
               next_s.phase = adcsp_pkg::PH_DATA;
               next_s.remain = full_byte[`ADCSP_INS_COUNT];
               next_s.byte_ptr =
                  (full_byte[`ADCSP_INS_START] == `ADCSP_START_HIGH) ?
                  `ADCSP_BYTE_TOP : full_byte[`ADCSP_INS_START];
               next_s.in_read = !full_byte[`ADCSP_INS_WRITE];
            end else begin
               if (s.instr[`ADCSP_INS_WRITE]) begin
                  case (s.instr[`ADCSP_INS_SEL])
                     `ADCSP_SEL_SETUP: next_s.regs.setup[lane +: 8] = full_byte;
                     `ADCSP_SEL_ZERO: next_s.regs.zero[lane +: 8] = full_byte;
                     `ADCSP_SEL_SPAN: begin
                        if (s.instr[`ADCSP_INS_NEG]) begin
                           next_s.regs.neg_span[lane +: 8] = full_byte;
                        end else begin
                           next_s.regs.pos_span[lane +: 8] = full_byte;
                        end
                     end
                     default: next_s.regs = s.regs;
                  endcase
               end
               next_s.byte_ptr = step_ptr;
               // counts survive deselection at a byte boundary
               if (s.remain == 2'h0) begin
                  next_s.phase = adcsp_pkg::PH_INSTR;
                  next_s.in_read = 1'b0;
               end else begin
                  next_s.remain = s.remain - 2'h1;
               end
            end
         end
      end
      // self clocking release waits for the byte, one cycle in the stall
      next_s.oe_r = next_s.in_read &&
                    (next_s.gen == adcsp_pkg::GEN_SHIFT || !select_n);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.phase <= adcsp_pkg::PH_INSTR;
         s.gen <= adcsp_pkg::GEN_IDLE;
         s.sclk_o <= 1'b1;
         s.sclk_prev <= 1'b1;
         s.regs.setup <= `ADCSP_SETUP_RST;
         s.regs.zero <= `ADCSP_ZERO_RST;
         s.regs.pos_span <= `ADCSP_SPAN_RST;
         s.regs.neg_span <= `ADCSP_SPAN_RST;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins
   // external mode release is combinational so it follows select at once
   assign drive = mode_strap ? s.oe_r :
                  s.in_read && !select_n;
   assign sdio_out = s.out_bit;
   assign serial_out_line = s.out_bit;
   assign sdio_oe = drive && s.regs.setup[`ADCSP_TWO_WIRE_BIT];
   assign serial_out_line_oe = drive && !s.regs.setup[`ADCSP_TWO_WIRE_BIT];
   assign shift_clock_out = s.sclk_o;
   assign shift_clock_oe = mode_strap;
   assign trim_regs = s.regs;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   one_wire_a: assert property (
      !(sdio_oe && serial_out_line_oe))
      else $error("both data outputs enabled");
   idle_hiz_a: assert property (
      (select_n && !mode_strap) |-> !sdio_oe && !serial_out_line_oe)
      else $error("output driven while deselected");
   ext_freeze_a: assert property (
      (!mode_strap && select_n) |=>
         $stable(s.bit_cnt) && $stable(s.phase) && $stable(s.remain))
      else $error("port advanced while deselected");
   park_high_a: assert property (
      (mode_strap && s.gen != adcsp_pkg::GEN_SHIFT && $past(mode_strap)
       && $past(s.gen) != adcsp_pkg::GEN_SHIFT) |-> shift_clock_out)
      else $error("generated clock parked low");
   start_delay_a: assert property (
      (mode_strap && s.gen == adcsp_pkg::GEN_WAIT &&
       s.gen_cnt == `ADCSP_START_LAST && !select_n) |=>
         shift_clock_out ##1 !shift_clock_out)
      else $error("first shift clock edge mistimed");
   stall_high_a: assert property (
      (mode_strap && s.gen == adcsp_pkg::GEN_SHIFT &&
       s.gen_cnt == `ADCSP_BYTE_LAST && !select_n) |=>
         shift_clock_out [*8])
      else $error("stall not held high");
   byte_finish_a: assert property (
      (mode_strap && s.gen == adcsp_pkg::GEN_SHIFT &&
       s.gen_cnt != `ADCSP_BYTE_LAST) |=> s.gen == adcsp_pkg::GEN_SHIFT)
      else $error("byte cut short");
   stall_release_a: assert property (
      (mode_strap && s.gen == adcsp_pkg::GEN_STALL && select_n) |=>
         !sdio_oe && !serial_out_line_oe)
      else $error("outputs not released in stall");
   read_drive_a: assert property (
      (mode_strap && s.gen == adcsp_pkg::GEN_SHIFT && s.in_read) |->
         sdio_oe || serial_out_line_oe)
      else $error("read output dropped inside byte");
   pause_keep_a: assert property (
      (mode_strap && s.gen == adcsp_pkg::GEN_IDLE) |=>
         $stable(s.phase) && $stable(s.remain))
      else $error("paused transfer lost");

   self_byte_c: cover property (
      mode_strap && s.gen == adcsp_pkg::GEN_STALL && !select_n);
   ext_write_c: cover property (
      !mode_strap && rise && s.phase == adcsp_pkg::PH_DATA &&
      s.instr[`ADCSP_INS_WRITE] && s.bit_cnt == `ADCSP_BIT_LAST);
   read_pause_c: cover property (
      s.in_read && select_n && s.phase == adcsp_pkg::PH_DATA);
   stall_exit_c: cover property (
      mode_strap && s.gen == adcsp_pkg::GEN_STALL && select_n);
endmodule : adcsp_port
